// >>> shared/clw_pkg.sv
/*
  constants for the charge level warning block: register indices, field
  positions, reset values and widths.
  assumes a 16-bit register port with word indices, one clock domain.
*/
`default_nettype none
package clw_pkg;
  // widths
  localparam int DW    = 16;
  localparam int AW    = 4;
  localparam int LVLW  = 8;
  localparam int EFFW  = 8;

  // register indices
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_INIT_SET  = 4'h1;
  localparam logic [3:0] ADDR_INIT_CLR  = 4'h2;
  localparam logic [3:0] ADDR_FINAL_SET = 4'h3;
  localparam logic [3:0] ADDR_FINAL_CLR = 4'h4;
  localparam logic [3:0] ADDR_FLAGS     = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'h7;
  localparam logic [3:0] ADDR_REM_CAP   = 4'h8;
  localparam logic [3:0] ADDR_LEVEL     = 4'h9;
  localparam logic [3:0] ADDR_EFF0      = 4'ha;
  localparam logic [3:0] ADDR_EFF3      = 4'hd;

  // field positions
  localparam int CTRL_HOLD_BIT  = 0;
  localparam int FLAG_INIT_BIT  = 0;
  localparam int FLAG_FINAL_BIT = 1;
  localparam int IRQ_INIT_SET   = 0;
  localparam int IRQ_INIT_CLR   = 1;
  localparam int IRQ_FINAL_SET  = 2;
  localparam int IRQ_FINAL_CLR  = 3;
  localparam int IRQW           = 4;

  // reset values, levels in mAh
  localparam logic [15:0] RST_INIT_SET  = 16'h0096;
  localparam logic [15:0] RST_INIT_CLR  = 16'h00af;
  localparam logic [15:0] RST_FINAL_SET = 16'h004b;
  localparam logic [15:0] RST_FINAL_CLR = 16'h0064;
  localparam logic [15:0] LEVEL_DISABLE = 16'hffff;
  localparam logic [7:0]  RST_EFF       = 8'h80;
  localparam int          EFF_SHIFT     = 7;

  // charge level bands that pick an efficiency factor
  localparam logic [7:0] BAND1_LVL = 8'h19;
  localparam logic [7:0] BAND2_LVL = 8'h32;
  localparam logic [7:0] BAND3_LVL = 8'h4b;
endpackage
`default_nettype wire

// >>> logic/clw_hyst_flag.sv
/*
  one warning flag with separate set and clear levels (hysteresis).
  assumes upd_i is a one-cycle pulse on sys_clk_i with cap_i valid beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module clw_hyst_flag #(
  parameter int W               = 16,
  parameter bit CLR_NEEDS_SET   = 1'b0,
  parameter bit SET_CAN_DISABLE = 1'b0
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // capacity update
  input  wire logic         upd_i,
  input  wire logic [W-1:0] cap_i,
  // levels
  input  wire logic [W-1:0] set_lvl_i,
  input  wire logic [W-1:0] clr_lvl_i,
  // flag and events
  output logic              flag_o,
  output logic              set_p_o,
  output logic              clr_p_o
);
  logic flag_q;
  logic flag_d;

  wire below    = $signed(cap_i) < $signed(set_lvl_i);
  wire above    = $signed(cap_i) > $signed(clr_lvl_i);
  wire disabled = SET_CAN_DISABLE && (set_lvl_i == {W{1'b1}});
  wire set_hit  = upd_i && below && !disabled;
  wire clr_hit  = upd_i && above && (flag_q || !CLR_NEEDS_SET) && !set_hit;

  assign flag_d  = set_hit ? 1'b1 : (clr_hit ? 1'b0 : flag_q);
  assign set_p_o = set_hit && !flag_q;
  assign clr_p_o = clr_hit && flag_q;
  assign flag_o  = flag_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  flag_set_a: assert property (
    upd_i && below && !disabled |=> flag_o)
    else $error("flag not set below set level");
  flag_clr_a: assert property (
    upd_i && above && flag_o && !below |=> !flag_o)
    else $error("flag not cleared above clear level");
  flag_hold_a: assert property (
    !upd_i |=> $stable(flag_o))
    else $error("flag moved without update");
  flag_off_a: assert property (
    upd_i && disabled && !flag_o |=> !flag_o)
    else $error("disabled flag was set");
  flag_set_c: cover property (upd_i && below && !flag_o ##1 flag_o);
endmodule
`default_nettype wire

// >>> logic/clw_eff_comp.sv
/*
  charge efficiency compensation: scales a raw charge increment by one of
  four factors (unity is 0x80).
  assumes raw_vld_i is a one-cycle pulse on sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module clw_eff_comp (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // raw increment
  input  wire logic [15:0] raw_i,
  input  wire logic        raw_vld_i,
  input  wire logic [1:0]  band_i,
  // factors
  input  wire logic [7:0]  eff0_i,
  input  wire logic [7:0]  eff1_i,
  input  wire logic [7:0]  eff2_i,
  input  wire logic [7:0]  eff3_i,
  // compensated increment
  output logic [15:0]      comp_o,
  output logic             comp_vld_o
);
  logic [15:0] comp_q;
  logic        vld_q;

  function automatic logic [15:0] scale(input logic [15:0] r, input logic [7:0] f);
    logic [23:0] p;
    p = r * f;
    scale = p[23] ? 16'hffff : p[clw_pkg::EFF_SHIFT +: 16];
  endfunction

  wire [7:0] fac = (band_i == 2'h0) ? eff0_i :
                   (band_i == 2'h1) ? eff1_i :
                   (band_i == 2'h2) ? eff2_i : eff3_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      comp_q <= 16'h0000;
      vld_q  <= 1'b0;
    end else begin
      vld_q  <= raw_vld_i;
      if (raw_vld_i) begin
        comp_q <= scale(raw_i, fac);
      end
    end
  end

  assign comp_o     = comp_q;
  assign comp_vld_o = vld_q;

  eff_scale_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raw_vld_i |=> comp_vld_o && comp_o == scale($past(raw_i), $past(fac)))
    else $error("efficiency scaling wrong");
endmodule
`default_nettype wire

// >>> logic/clw_top.sv
/*
  charge level warning block: two low-charge flags with hysteresis, charge
  level hold during discharge, efficiency compensation, registers, irq.
  assumes the estimator drives capacity, level and charge inputs on
  sys_clk_i (40 MHz) with one-cycle update pulses; registers over a plain
  port with read data one cycle after the read strobe.
*/
// Contract
// - set initial flag when remaining capacity drops below its set level
// - clear initial flag only when capacity rises above its clear level
// - set final flag when capacity drops below the final set level
// - final set level of minus one keeps the final flag from setting
// - clear final flag only if set and capacity above final clear level
// - with hold enabled, reported level never rises during discharge once a first level update has been taken
// - thresholds and remaining capacity are all in mAh
// - both flags readable as bits of the status flag word
// - charge compensation uses four separately programmable efficiency factors
`timescale 1ns/1ps
`default_nettype none
module clw_top (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [15:0]      reg_rdata_o,
  // estimator side
  input  wire logic [15:0] remaining_capacity_value_i,
  input  wire logic        rem_cap_upd_i,
  input  wire logic [7:0]  calc_level_i,
  input  wire logic        calc_level_upd_i,
  input  wire logic        discharging_i,
  input  wire logic [15:0] chg_raw_i,
  input  wire logic        chg_raw_vld_i,
  // results
  output logic             low_charge_initial_flag_o,
  output logic             low_charge_final_flag_o,
  output logic [7:0]       reported_level_o,
  output logic [15:0]      chg_comp_o,
  output logic             chg_comp_vld_o,
  output logic             irq_o
);
  logic        hold_en_q;
  logic [15:0] init_set_q;
  logic [15:0] init_clr_q;
  logic [15:0] final_set_q;
  logic [15:0] final_clr_q;
  logic [15:0] rem_cap_q;
  logic [7:0]  level_q;
  logic        level_seen_q;
  logic [3:0]  irq_stat_q;
  logic [3:0]  irq_stat_d;
  logic [3:0]  irq_mask_q;
  logic [7:0]  eff_q [4];
  logic [15:0] rdata_q;
  logic [7:0]  level_d;

  logic init_flag;
  logic final_flag;
  logic init_set_p;
  logic init_clr_p;
  logic final_set_p;
  logic final_clr_p;

  function automatic logic [1:0] band(input logic [7:0] lvl);
    band = (lvl >= clw_pkg::BAND3_LVL) ? 2'h3 :
           (lvl >= clw_pkg::BAND2_LVL) ? 2'h2 :
           (lvl >= clw_pkg::BAND1_LVL) ? 2'h1 : 2'h0;
  endfunction

  // write decode
  wire wr_ctrl  = reg_wr_i && (reg_addr_i == clw_pkg::ADDR_CTRL);
  wire wr_iset  = reg_wr_i && (reg_addr_i == clw_pkg::ADDR_INIT_SET);
  wire wr_iclr  = reg_wr_i && (reg_addr_i == clw_pkg::ADDR_INIT_CLR);
  wire wr_fset  = reg_wr_i && (reg_addr_i == clw_pkg::ADDR_FINAL_SET);
  wire wr_fclr  = reg_wr_i && (reg_addr_i == clw_pkg::ADDR_FINAL_CLR);
  wire wr_istat = reg_wr_i && (reg_addr_i == clw_pkg::ADDR_IRQ_STAT);
  wire wr_imask = reg_wr_i && (reg_addr_i == clw_pkg::ADDR_IRQ_MASK);
  wire wr_eff   = reg_wr_i && (reg_addr_i >= clw_pkg::ADDR_EFF0)
                           && (reg_addr_i <= clw_pkg::ADDR_EFF3);
  wire [1:0] eff_idx = 2'(reg_addr_i - clw_pkg::ADDR_EFF0);

  wire [15:0] flag_word = {14'h0000, final_flag, init_flag};

  // read select, unmapped reads zero
  wire wr_eff_rd = (reg_addr_i >= clw_pkg::ADDR_EFF0) && (reg_addr_i <= clw_pkg::ADDR_EFF3);
  wire [15:0] rd_mux =
    (reg_addr_i == clw_pkg::ADDR_CTRL)      ? {15'h0000, hold_en_q} :
    (reg_addr_i == clw_pkg::ADDR_INIT_SET)  ? init_set_q  :
    (reg_addr_i == clw_pkg::ADDR_INIT_CLR)  ? init_clr_q  :
    (reg_addr_i == clw_pkg::ADDR_FINAL_SET) ? final_set_q :
    (reg_addr_i == clw_pkg::ADDR_FINAL_CLR) ? final_clr_q :
    (reg_addr_i == clw_pkg::ADDR_FLAGS)     ? flag_word   :
    (reg_addr_i == clw_pkg::ADDR_IRQ_STAT)  ? {12'h000, irq_stat_q} :
    (reg_addr_i == clw_pkg::ADDR_IRQ_MASK)  ? {12'h000, irq_mask_q} :
    (reg_addr_i == clw_pkg::ADDR_REM_CAP)   ? rem_cap_q :
    (reg_addr_i == clw_pkg::ADDR_LEVEL)     ? {8'h00, level_q} :
    wr_eff_rd                               ? {8'h00, eff_q[eff_idx]} : 16'h0000;

  clw_hyst_flag #(
    .W               (16),
    .CLR_NEEDS_SET   (1'b0),
    .SET_CAN_DISABLE (1'b0)
  ) u_init (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .upd_i     (rem_cap_upd_i),
    .cap_i     (remaining_capacity_value_i),
    .set_lvl_i (init_set_q),
    .clr_lvl_i (init_clr_q),
    .flag_o    (init_flag),
    .set_p_o   (init_set_p),
    .clr_p_o   (init_clr_p)
  );

  clw_hyst_flag #(
    .W               (16),
    .CLR_NEEDS_SET   (1'b1),
    .SET_CAN_DISABLE (1'b1)
  ) u_final (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .upd_i     (rem_cap_upd_i),
    .cap_i     (remaining_capacity_value_i),
    .set_lvl_i (final_set_q),
    .clr_lvl_i (final_clr_q),
    .flag_o    (final_flag),
    .set_p_o   (final_set_p),
    .clr_p_o   (final_clr_p)
  );

  // efficiency band of the reported level
  wire [1:0] lvl_band = band(level_q);

  clw_eff_comp u_eff (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .raw_i      (chg_raw_i),
    .raw_vld_i  (chg_raw_vld_i),
    .band_i     (lvl_band),
    .eff0_i     (eff_q[0]),
    .eff1_i     (eff_q[1]),
    .eff2_i     (eff_q[2]),
    .eff3_i     (eff_q[3]),
    .comp_o     (chg_comp_o),
    .comp_vld_o (chg_comp_vld_o)
  );

  wire hold_now = hold_en_q && discharging_i && level_seen_q && (calc_level_i > level_q);
  assign level_d = (calc_level_upd_i && !hold_now) ? calc_level_i : level_q;

  // events set, write one clears; set wins
  wire [3:0] irq_ev = {final_clr_p, final_set_p, init_clr_p, init_set_p};
  assign irq_stat_d = (irq_stat_q & ~(wr_istat ? reg_wdata_i[3:0] : 4'h0)) | irq_ev;

  // config registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hold_en_q   <= 1'b0;
      init_set_q  <= clw_pkg::RST_INIT_SET;
      init_clr_q  <= clw_pkg::RST_INIT_CLR;
      final_set_q <= clw_pkg::RST_FINAL_SET;
      final_clr_q <= clw_pkg::RST_FINAL_CLR;
      irq_mask_q  <= 4'h0;
      eff_q       <= '{default: clw_pkg::RST_EFF};
    end else begin
      if (wr_ctrl)  hold_en_q   <= reg_wdata_i[clw_pkg::CTRL_HOLD_BIT];
      if (wr_iset)  init_set_q  <= reg_wdata_i;
      if (wr_iclr)  init_clr_q  <= reg_wdata_i;
      if (wr_fset)  final_set_q <= reg_wdata_i;
      if (wr_fclr)  final_clr_q <= reg_wdata_i;
      if (wr_imask) irq_mask_q  <= reg_wdata_i[3:0];
      if (wr_eff)   eff_q[eff_idx] <= reg_wdata_i[7:0];
    end
  end

  // state registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rem_cap_q    <= 16'h0000;
      level_q      <= 8'h00;
      level_seen_q <= 1'b0;
      irq_stat_q   <= 4'h0;
      rdata_q      <= 16'h0000;
    end else begin
      if (rem_cap_upd_i) rem_cap_q <= remaining_capacity_value_i;
      if (calc_level_upd_i) level_seen_q <= 1'b1;
      level_q    <= level_d;
      irq_stat_q <= irq_stat_d;
      rdata_q    <= reg_rd_i ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata_o               = rdata_q;
  assign low_charge_initial_flag_o = init_flag;
  assign low_charge_final_flag_o   = final_flag;
  assign reported_level_o          = level_q;
  assign irq_o                     = |(irq_stat_q & irq_mask_q);

  // signed compares seen by the checks below
  wire cap_lt_iset = $signed(remaining_capacity_value_i) < $signed(init_set_q);
  wire cap_gt_iclr = $signed(remaining_capacity_value_i) > $signed(init_clr_q);
  wire cap_lt_fset = $signed(remaining_capacity_value_i) < $signed(final_set_q);
  wire cap_gt_fclr = $signed(remaining_capacity_value_i) > $signed(final_clr_q);
  wire fset_off    = (final_set_q == clw_pkg::LEVEL_DISABLE);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  level_hold_a: assert property (
    calc_level_upd_i && hold_now |=> $stable(reported_level_o))
    else $error("held level rose during discharge");
  level_follow_a: assert property (
    calc_level_upd_i && !hold_now |=> reported_level_o == $past(calc_level_i))
    else $error("reported level did not follow");
  flag_word_a: assert property (
    reg_rd_i && reg_addr_i == clw_pkg::ADDR_FLAGS
    |=> reg_rdata_o == {14'h0000, $past(final_flag), $past(init_flag)})
    else $error("status flag word mismatch");
  irq_raise_a: assert property (
    init_set_p && irq_mask_q[0] && !wr_imask |=> irq_o)
    else $error("masked-in event did not raise irq");

  init_set_a: assert property (
    rem_cap_upd_i && cap_lt_iset
    |=> low_charge_initial_flag_o)
    else $error("initial flag not set below its set level");
  init_keep_a: assert property (
    low_charge_initial_flag_o && !(rem_cap_upd_i && cap_gt_iclr)
    |=> low_charge_initial_flag_o)
    else $error("initial flag cleared without a rise above clear level");
  init_clear_a: assert property (
    rem_cap_upd_i && cap_gt_iclr && !cap_lt_iset
    |=> !low_charge_initial_flag_o)
    else $error("initial flag not cleared above its clear level");
  final_set_a: assert property (
    rem_cap_upd_i && cap_lt_fset && !fset_off
    |=> low_charge_final_flag_o)
    else $error("final flag not set below its set level");
  final_off_a: assert property (
    rem_cap_upd_i && fset_off && !low_charge_final_flag_o
    |=> !low_charge_final_flag_o)
    else $error("final flag set while its set level is minus one");
  final_keep_a: assert property (
    low_charge_final_flag_o && !(rem_cap_upd_i && cap_gt_fclr)
    |=> low_charge_final_flag_o)
    else $error("final flag cleared without a rise above clear level");
  final_clear_a: assert property (
    rem_cap_upd_i && cap_gt_fclr && low_charge_final_flag_o && !(cap_lt_fset && !fset_off)
    |=> !low_charge_final_flag_o)
    else $error("final flag not cleared above its clear level");
  final_idle_a: assert property (
    !low_charge_final_flag_o && !(rem_cap_upd_i && cap_lt_fset && !fset_off)
    |=> !low_charge_final_flag_o)
    else $error("final flag set without a qualifying update");

  rem_cap_a: assert property (
    rem_cap_upd_i
    |=> rem_cap_q == $past(remaining_capacity_value_i))
    else $error("remaining capacity register not updated");
  level_max_a: assert property (
    hold_en_q && discharging_i && level_seen_q
    |=> reported_level_o <= $past(reported_level_o))
    else $error("reported level rose while held");
  eff_write_a: assert property (
    wr_eff
    |=> eff_q[$past(eff_idx)] == $past(reg_wdata_i[7:0]))
    else $error("efficiency factor write lost");
  hold_write_a: assert property (
    wr_ctrl
    |=> hold_en_q == $past(reg_wdata_i[clw_pkg::CTRL_HOLD_BIT]))
    else $error("hold option write lost");
  iset_write_a: assert property (
    wr_iset
    |=> init_set_q == $past(reg_wdata_i))
    else $error("initial set level write lost");

  rdata_idle_a: assert property (
    !reg_rd_i
    |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside read cycle");
  irq_w1c_a: assert property (
    wr_istat
    |=> (irq_stat_q & $past(reg_wdata_i[3:0] & ~irq_ev)) == 4'h0)
    else $error("irq status bit not cleared by write one");
  irq_sticky_a: assert property (
    !wr_istat
    |=> (irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q))
    else $error("irq status bit lost without clear");
  irq_event_a: assert property (
    |irq_ev
    |=> (irq_stat_q & $past(irq_ev)) == $past(irq_ev))
    else $error("flag event did not set irq status");

  hold_c: cover property (calc_level_upd_i && hold_now);
  irq_c: cover property (!irq_o ##1 irq_o);
  final_c: cover property (final_set_p ##[1:200] final_clr_p);
  flag_word_c: cover property (reg_rd_i && reg_addr_i == clw_pkg::ADDR_FLAGS && final_flag);
endmodule
`default_nettype wire

// >>> sim/clw_host.sv
/*
  host side of the register port: one-cycle writes and reads.
  assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module clw_host (
  // clock
  input  wire logic        sys_clk_i,
  // register port
  output logic [3:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  input  wire logic [15:0] reg_rdata_i
);
  initial begin
    reg_addr_o  = 4'h0;
    reg_wdata_o = 16'h0000;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o    <= 1'b0;
    // stale data must not look valid
    reg_wdata_o <= ~d;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o   <= 1'b0;
    #1;
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> sim/charge_level_warning_flags_tb.sv
/*
  self-checking bench for the charge level warning block.
  assumes the host model drives the register port; estimator side from here.
*/
`timescale 1ns/1ps
`default_nettype none
module charge_level_warning_flags_tb;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, cap, raw, comp, rv;
  logic        wr, rd, cap_upd, lvl_upd, dis, raw_vld, fi, ff, comp_vld, irq;
  logic [7:0]  lvl, rep;
  int          n_fail = 0;
  int          checks = 0;

  initial begin
    cap = 16'h0200; cap_upd = 1'b0; lvl = 8'h00; lvl_upd = 1'b0;
    dis = 1'b0; raw = 16'h0000; raw_vld = 1'b0;
  end
  always #12.5 sys_clk_i = ~sys_clk_i;

  clw_host host (.sys_clk_i(sys_clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));

  clw_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .remaining_capacity_value_i(cap), .rem_cap_upd_i(cap_upd),
    .calc_level_i(lvl), .calc_level_upd_i(lvl_upd), .discharging_i(dis),
    .chg_raw_i(raw), .chg_raw_vld_i(raw_vld),
    .low_charge_initial_flag_o(fi), .low_charge_final_flag_o(ff),
    .reported_level_o(rep), .chg_comp_o(comp), .chg_comp_vld_o(comp_vld),
    .irq_o(irq));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    host.rd_reg(a, rv);
    chk(rv, exp);
  endtask

  // one capacity update, flags judged one cycle later
  task automatic cap_chk(input logic [15:0] v, input logic ei, input logic ef);
    @(posedge sys_clk_i);
    cap     <= v;
    cap_upd <= 1'b1;
    @(posedge sys_clk_i);
    cap_upd <= 1'b0;
    #1;
    chk({14'h0, ff, fi}, {14'h0, ef, ei});
  endtask

  task automatic lvl_chk(input logic [7:0] v, input logic [7:0] exp);
    @(posedge sys_clk_i);
    lvl     <= v;
    lvl_upd <= 1'b1;
    @(posedge sys_clk_i);
    lvl_upd <= 1'b0;
    #1;
    chk({8'h0, rep}, {8'h0, exp});
  endtask

  // one raw increment, compensated value judged while its valid stands
  task automatic raw_chk(input logic [15:0] r, input logic [15:0] exp);
    @(posedge sys_clk_i);
    raw     <= r;
    raw_vld <= 1'b1;
    @(posedge sys_clk_i);
    raw_vld <= 1'b0;
    #1;
    chk({15'h0, comp_vld}, 16'h0001);
    chk(comp, exp);
    @(posedge sys_clk_i);
    #1;
    chk({15'h0, comp_vld}, 16'h0000);
  endtask

  task automatic t_reset_vals;
    chk({5'h00, ff, fi, irq, rep}, 16'h0000);
    rchk(clw_pkg::ADDR_REM_CAP, 16'h0000);
    host.wr_reg(clw_pkg::ADDR_FLAGS, 16'hffff);
    rchk(clw_pkg::ADDR_FLAGS, 16'h0000);
    rchk(clw_pkg::ADDR_INIT_SET, 16'h0096);
    rchk(clw_pkg::ADDR_INIT_CLR, 16'h00af);
    rchk(clw_pkg::ADDR_FINAL_SET, 16'h004b);
    rchk(clw_pkg::ADDR_FINAL_CLR, 16'h0064);
    rchk(clw_pkg::ADDR_IRQ_MASK, 16'h0000);
    rchk(clw_pkg::ADDR_EFF3, 16'h0080);
    rchk(4'he, 16'h0000);
  endtask

  task automatic t_irq;
    host.wr_reg(clw_pkg::ADDR_IRQ_MASK, 16'h0001);
    cap_chk(16'h0010, 1'b1, 1'b1);
    rchk(clw_pkg::ADDR_IRQ_STAT, 16'h0005);
    chk({15'h0, irq}, 16'h0001);
    host.wr_reg(clw_pkg::ADDR_IRQ_STAT, 16'h0001);
    #1;
    chk({15'h0, irq}, 16'h0000);
    rchk(clw_pkg::ADDR_IRQ_STAT, 16'h0004);
    host.wr_reg(clw_pkg::ADDR_IRQ_MASK, 16'h0000);
    cap_chk(16'h0200, 1'b0, 1'b0);
    rchk(clw_pkg::ADDR_IRQ_STAT, 16'h000e);
    chk({15'h0, irq}, 16'h0000);
    host.wr_reg(clw_pkg::ADDR_IRQ_STAT, 16'h000f);
  endtask

  task automatic t_initial;
    cap_chk(16'h0096, 1'b0, 1'b0);
    cap_chk(16'h0095, 1'b1, 1'b0);
    rchk(clw_pkg::ADDR_FLAGS, 16'h0001);
    cap_chk(16'h00af, 1'b1, 1'b0);
    cap_chk(16'h00b0, 1'b0, 1'b0);
  endtask

  task automatic t_final;
    cap_chk(16'h004b, 1'b1, 1'b0);
    cap_chk(16'h004a, 1'b1, 1'b1);
    rchk(clw_pkg::ADDR_FLAGS, 16'h0003);
    cap_chk(16'h0064, 1'b1, 1'b1);
    cap_chk(16'h0065, 1'b1, 1'b0);
    cap_chk(16'h00b0, 1'b0, 1'b0);
    host.wr_reg(clw_pkg::ADDR_FINAL_SET, clw_pkg::LEVEL_DISABLE);
    cap_chk(16'hfff0, 1'b1, 1'b0);
    cap_chk(16'h0200, 1'b0, 1'b0);
    rchk(clw_pkg::ADDR_REM_CAP, 16'h0200);
  endtask

  task automatic t_hold;
    host.wr_reg(clw_pkg::ADDR_CTRL, 16'h0001);
    rchk(clw_pkg::ADDR_CTRL, 16'h0001);
    dis <= 1'b1;
    lvl_chk(8'h32, 8'h32);
    lvl_chk(8'h3c, 8'h32);
    lvl_chk(8'h28, 8'h28);
    rchk(clw_pkg::ADDR_LEVEL, 16'h0028);
    dis <= 1'b0;
    lvl_chk(8'h46, 8'h46);
  endtask

  task automatic t_eff;
    logic [7:0] lv [4];
    logic [7:0] f  [4];
    lv = '{8'h10, 8'h20, 8'h40, 8'h60};
    f  = '{8'h40, 8'h60, 8'ha0, 8'hc0};
    for (int i = 0; i < 4; i++) begin
      host.wr_reg(4'(clw_pkg::ADDR_EFF0 + i), {8'h0, f[i]});
    end
    for (int i = 0; i < 4; i++) begin
      lvl_chk(lv[i], lv[i]);
      raw_chk(16'h0100, {7'h0, f[i], 1'b0});
    end
    // top band factor above unity saturates a full-scale increment
    raw_chk(16'hffff, 16'hffff);
  endtask

  task automatic wrap_up;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_irq();
    t_initial();
    t_final();
    t_hold();
    t_eff();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
